// *** rtl/brf_framer.v ***
// Purpose: Block response transmit framer and general receive FIFO loader
// Assumes: Host and link logic share clk_sys; 32-bit quadlets
// Notes: Transmit path parses and forwards; receive path prepends a token
`include "brf_map.vh"
`default_nettype none
// Summary of operation
// - Speed 00/01/10 valid, 11 flagged
// - Retry code passed through, only the new encoding flagged
// - Destination splits into bus and node numbers
// - Response codes decoded, reserved ones flagged
// - One receive FIFO for async and isochronous
// - Block length field sets packet end
// - Stored order is the order read back
// - Four quadlet packet types accepted
// - Status token stored before each packet
module brf_framer #(
  parameter GRF_DEPTH = `BRF_GRF_DEPTH,
  parameter GRF_AW = `BRF_GRF_AW
) (
  // Clock and reset
  input wire clk_sys,
  input wire srst,
  // Host transmit quadlets
  input wire tx_valid,
  input wire [31:0] tx_data,
  output wire tx_ready,
  // Link transmit quadlets
  output reg link_tx_valid,
  output reg [31:0] link_tx_data,
  output reg link_tx_last,
  input wire link_tx_ready,
  // Decoded transmit header
  output reg [1:0] speed_code,
  output reg speed_bad,
  output reg [5:0] transaction_label,
  output reg [1:0] retry_code,
  output reg retry_is_new,
  output reg [3:0] transaction_code,
  output reg [15:0] dest_node_id,
  output reg [9:0] dest_bus_num,
  output reg [5:0] dest_node_num,
  output reg [3:0] response_code,
  output reg response_reserved,
  output reg [15:0] payload_byte_count,
  output reg [15:0] extended_transaction_code,
  // Link receive quadlets
  input wire rx_in_valid,
  input wire [31:0] rx_in_data,
  input wire rx_in_last,
  input wire [4:0] rx_in_status,
  output wire rx_in_ready,
  output reg rx_len_mismatch,
  // Host reads general receive FIFO
  output wire grf_rd_valid,
  output wire [31:0] grf_rd_data,
  output wire grf_rd_last,
  input wire grf_rd_ready
);
  localparam RX_IDLE = 1'b0;
  localparam RX_BODY = 1'b1;

  // Whole quadlets needed for a byte count, rounding up
  function [16:0] brf_quads;
    input [15:0] bytes;
    begin
      brf_quads = ({1'b0, bytes} + 17'h00003) >> 2;
    end
  endfunction

  // Quadlet packet length from link, zero when not a quadlet type
  function [16:0] brf_qlen;
    input [3:0] tc;
    begin
      case (tc)
        `BRF_TC_QWR_REQ: brf_qlen = 17'h00004;
        `BRF_TC_QRD_REQ: brf_qlen = 17'h00003;
        `BRF_TC_WR_RESP: brf_qlen = 17'h00003;
        `BRF_TC_QRD_RESP: brf_qlen = 17'h00004;
        default: brf_qlen = 17'h00000;
      endcase
    end
  endfunction

  // Transmit side
  reg [2:0] tx_idx;
  reg [16:0] tx_rem;
  wire tx_take;
  wire [16:0] q3_quads;

  assign tx_ready = !link_tx_valid || link_tx_ready;
  assign tx_take = tx_valid && tx_ready;
  assign q3_quads = brf_quads(tx_data[`BRF_LEN_HI:`BRF_LEN_LO]);

  always @(posedge clk_sys) begin
    if (srst) begin
      tx_idx <= 3'h0;
      tx_rem <= 17'h00000;
      link_tx_valid <= 1'b0;
      link_tx_data <= 32'h00000000;
      link_tx_last <= 1'b0;
      speed_code <= `BRF_SPD_S100;
      speed_bad <= 1'b0;
      transaction_label <= 6'h00;
      retry_code <= `BRF_RT_NEW;
      retry_is_new <= 1'b1;
      transaction_code <= 4'h0;
      dest_node_id <= 16'h0000;
      dest_bus_num <= 10'h000;
      dest_node_num <= 6'h00;
      response_code <= `BRF_RC_COMPLETE;
      response_reserved <= 1'b0;
      payload_byte_count <= 16'h0000;
      extended_transaction_code <= 16'h0000;
    end else begin
      if (link_tx_valid && link_tx_ready && !tx_take) begin
        link_tx_valid <= 1'b0;
      end
      if (tx_take) begin
        link_tx_valid <= 1'b1;
        link_tx_data <= tx_data;
        link_tx_last <= 1'b0;
        case (tx_idx)
          3'h0: begin
            speed_code <= tx_data[`BRF_SPD_HI:`BRF_SPD_LO];
            speed_bad <= (tx_data[`BRF_SPD_HI:`BRF_SPD_LO] == `BRF_SPD_BAD);
            transaction_label <= tx_data[`BRF_TLBL_HI:`BRF_TLBL_LO];
            retry_code <= tx_data[`BRF_RTRY_HI:`BRF_RTRY_LO];
            retry_is_new <= (tx_data[`BRF_RTRY_HI:`BRF_RTRY_LO] == `BRF_RT_NEW);
            transaction_code <= tx_data[`BRF_TRANSACTION_CODE_HI:`BRF_TRANSACTION_CODE_LO];
            tx_idx <= 3'h1;
          end
          3'h1: begin
            dest_node_id <= tx_data[`BRF_DEST_HI:`BRF_DEST_LO];
            dest_bus_num <= tx_data[`BRF_BUS_HI:`BRF_BUS_LO];
            dest_node_num <= tx_data[`BRF_NODE_HI:`BRF_NODE_LO];
            response_code <= tx_data[`BRF_RESPONSE_CODE_HI:`BRF_RESPONSE_CODE_LO];
            case (tx_data[`BRF_RESPONSE_CODE_HI:`BRF_RESPONSE_CODE_LO])
              `BRF_RC_COMPLETE, `BRF_RC_CONFLICT, `BRF_RC_DATA,
              `BRF_RC_TYPE, `BRF_RC_ADDR: response_reserved <= 1'b0;
              default: response_reserved <= 1'b1;
            endcase
            tx_idx <= 3'h2;
          end
          3'h2: begin
            tx_idx <= `BRF_TX_HDR_LAST;
          end
          3'h3: begin
            payload_byte_count <= tx_data[`BRF_LEN_HI:`BRF_LEN_LO];
            extended_transaction_code <= tx_data[`BRF_EXT_HI:`BRF_EXT_LO];
            tx_rem <= q3_quads;
            if (q3_quads == 17'h00000) begin
              link_tx_last <= 1'b1;
              tx_idx <= 3'h0;
            end else begin
              tx_idx <= 3'h4;
            end
          end
          default: begin
            tx_rem <= tx_rem - 17'h00001;
            if (tx_rem == 17'h00001) begin
              link_tx_last <= 1'b1;
              tx_idx <= 3'h0;
            end
          end
        endcase
      end
    end
  end

  // Receive side
  reg rx_state;
  reg [3:0] rx_transaction_code;
  reg [16:0] rx_idx;
  reg [16:0] rx_total;
  reg rx_known_len;
  reg [16:0] next_total;
  reg next_known;
  reg rx_eop;
  wire rx_iso;
  wire [16:0] rx_qlen;
  wire rx_block;
  wire rx_take;
  wire grf_wr_valid;
  wire [32:0] grf_wr_data;
  wire grf_wr_ready;
  wire [31:0] rx_token;

  assign rx_iso = (rx_transaction_code == `BRF_TC_ISO);
  assign rx_qlen = brf_qlen(rx_transaction_code);
  assign rx_block = rx_iso || (rx_transaction_code == `BRF_TC_BWR_REQ) ||
    (rx_transaction_code == `BRF_TC_BRD_REQ) || (rx_transaction_code == `BRF_TC_BRD_RESP);

  // Token built from the first link quadlet, before it is stored
  assign rx_token = {11'h000, rx_in_status, 6'h00,
    (brf_qlen(rx_in_data[`BRF_TRANSACTION_CODE_HI:`BRF_TRANSACTION_CODE_LO]) != 17'h00000) ||
    (rx_in_data[`BRF_TRANSACTION_CODE_HI:`BRF_TRANSACTION_CODE_LO] == `BRF_TC_ISO) ||
    (rx_in_data[`BRF_TRANSACTION_CODE_HI:`BRF_TRANSACTION_CODE_LO] == `BRF_TC_BWR_REQ) ||
    (rx_in_data[`BRF_TRANSACTION_CODE_HI:`BRF_TRANSACTION_CODE_LO] == `BRF_TC_BRD_REQ) ||
    (rx_in_data[`BRF_TRANSACTION_CODE_HI:`BRF_TRANSACTION_CODE_LO] == `BRF_TC_BRD_RESP),
    (rx_in_data[`BRF_TRANSACTION_CODE_HI:`BRF_TRANSACTION_CODE_LO] == `BRF_TC_ISO),
    rx_in_data[`BRF_TRANSACTION_CODE_HI:`BRF_TRANSACTION_CODE_LO], 4'h0};

  // Idle spends one cycle storing the token; link quadlet waits
  assign rx_in_ready = (rx_state == RX_BODY) && grf_wr_ready;
  assign rx_take = rx_in_valid && rx_in_ready;
  assign grf_wr_valid = rx_in_valid;
  assign grf_wr_data = (rx_state == RX_IDLE) ? {1'b0, rx_token} : {rx_eop, rx_in_data};

  always @* begin
    next_total = rx_total;
    next_known = rx_known_len;
    if (rx_iso && rx_idx == 17'h00000) begin
      next_total = `BRF_RX_IHDR + brf_quads(rx_in_data[`BRF_LEN_HI:`BRF_LEN_LO]);
      next_known = 1'b1;
    end else if (!rx_iso && rx_block && rx_idx == `BRF_RX_ALEN_IDX) begin
      next_total = `BRF_RX_AHDR + brf_quads(rx_in_data[`BRF_LEN_HI:`BRF_LEN_LO]);
      next_known = 1'b1;
    end
    if (rx_qlen != 17'h00000) begin
      rx_eop = (rx_idx + 17'h00001 == rx_qlen);
    end else if (rx_block) begin
      rx_eop = next_known && (rx_idx + 17'h00001 == next_total);
    end else begin
      rx_eop = rx_in_last;
    end
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      rx_state <= RX_IDLE;
      rx_transaction_code <= 4'h0;
      rx_idx <= 17'h00000;
      rx_total <= 17'h00000;
      rx_known_len <= 1'b0;
      rx_len_mismatch <= 1'b0;
    end else begin
      rx_len_mismatch <= 1'b0;
      case (rx_state)
        RX_IDLE: begin
          if (rx_in_valid && grf_wr_ready) begin
            rx_transaction_code <= rx_in_data[`BRF_TRANSACTION_CODE_HI:`BRF_TRANSACTION_CODE_LO];
            rx_idx <= 17'h00000;
            rx_known_len <= 1'b0;
            rx_state <= RX_BODY;
          end
        end
        RX_BODY: begin
          if (rx_take) begin
            rx_total <= next_total;
            rx_known_len <= next_known;
            rx_idx <= rx_idx + 17'h00001;
            rx_len_mismatch <= (rx_in_last != rx_eop);
            if (rx_eop) begin
              rx_state <= RX_IDLE;
            end
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // Shared by async and isochronous traffic, stored in arrival order
  brf_sync_fifo #(
    .WIDTH(33),
    .DEPTH(GRF_DEPTH),
    .AW(GRF_AW)
  ) u_general_receive_fifo (
    .clk_sys(clk_sys),
    .srst(srst),
    .wr_valid(grf_wr_valid),
    .wr_data(grf_wr_data),
    .wr_ready(grf_wr_ready),
    .rd_valid(grf_rd_valid),
    .rd_data({grf_rd_last, grf_rd_data}),
    .rd_ready(grf_rd_ready)
  );
endmodule // brf_framer
`default_nettype wire

// *** rtl/brf_map.vh ***
// Purpose: Field positions, codes and sizes for the block framer
// Assumes: 32-bit quadlets, bit 31 is the first bit on the wire
// Notes: Definitions only
`ifndef BRF_MAP_VH
`define BRF_MAP_VH
// Transmit quadlet 0: packet control
`define BRF_SPD_HI 17
`define BRF_SPD_LO 16
`define BRF_TLBL_HI 15
`define BRF_TLBL_LO 10
`define BRF_RTRY_HI 9
`define BRF_RTRY_LO 8
`define BRF_TRANSACTION_CODE_HI 7
`define BRF_TRANSACTION_CODE_LO 4
`define BRF_PRIO_HI 3
`define BRF_PRIO_LO 0
// Transmit quadlet 1: destination and response code
`define BRF_DEST_HI 31
`define BRF_DEST_LO 16
`define BRF_BUS_HI 31
`define BRF_BUS_LO 22
`define BRF_NODE_HI 21
`define BRF_NODE_LO 16
`define BRF_RESPONSE_CODE_HI 15
`define BRF_RESPONSE_CODE_LO 12
// Quadlet carrying byte count and extended code
`define BRF_LEN_HI 31
`define BRF_LEN_LO 16
`define BRF_EXT_HI 15
`define BRF_EXT_LO 0
// Header quadlet indices
`define BRF_TX_HDR_LAST 3'h3
`define BRF_RX_ALEN_IDX 17'h00003
`define BRF_RX_AHDR 17'h00004
`define BRF_RX_IHDR 17'h00001
// Speed codes
`define BRF_SPD_S100 2'h0
`define BRF_SPD_S200 2'h1
`define BRF_SPD_S400 2'h2
`define BRF_SPD_BAD 2'h3
// Retry codes
`define BRF_RT_NEW 2'h0
`define BRF_RT_X 2'h1
`define BRF_RT_A 2'h2
`define BRF_RT_B 2'h3
// Response codes
`define BRF_RC_COMPLETE 4'h0
`define BRF_RC_CONFLICT 4'h4
`define BRF_RC_DATA 4'h5
`define BRF_RC_TYPE 4'h6
`define BRF_RC_ADDR 4'h7
// Transaction codes
`define BRF_TC_QWR_REQ 4'h0
`define BRF_TC_BWR_REQ 4'h1
`define BRF_TC_WR_RESP 4'h2
`define BRF_TC_QRD_REQ 4'h4
`define BRF_TC_BRD_REQ 4'h5
`define BRF_TC_QRD_RESP 4'h6
`define BRF_TC_BRD_RESP 4'h7
`define BRF_TC_ISO 4'hA
// Packet token fields
`define BRF_TOK_STAT_HI 20
`define BRF_TOK_STAT_LO 16
`define BRF_TOK_KNOWN 9
`define BRF_TOK_ISO 8
`define BRF_TOK_TC_HI 7
`define BRF_TOK_TC_LO 4
// Storage sizes
`define BRF_GRF_DEPTH 64
`define BRF_GRF_AW 6
`endif

// *** rtl/brf_sync_fifo.v ***
// Purpose: Flip-flop FIFO holding received quadlets with end marks
// Assumes: One clock, synchronous active-high reset
// Notes: Read data comes straight from the storage flops
`default_nettype none
module brf_sync_fifo #(
  parameter WIDTH = 33,
  parameter DEPTH = 64,
  parameter AW = 6
) (
  // Clock and reset
  input wire clk_sys,
  input wire srst,
  // Fill side
  input wire wr_valid,
  input wire [WIDTH-1:0] wr_data,
  output wire wr_ready,
  // Drain side
  output wire rd_valid,
  output wire [WIDTH-1:0] rd_data,
  input wire rd_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire do_wr;
  wire do_rd;

  assign wr_ready = (count != DEPTH[AW:0]);
  assign rd_valid = (count != {(AW+1){1'b0}});
  assign rd_data = mem[rd_ptr];
  assign do_wr = wr_valid & wr_ready;
  assign do_rd = rd_valid & rd_ready;

  // Storage has no reset; only pointers matter
  always @(posedge clk_sys) begin
    if (do_wr) begin
      mem[wr_ptr] <= wr_data;
    end
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count <= count + 1'b1;
      end else if (do_rd && !do_wr) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // brf_sync_fifo
`default_nettype wire

// *** bench/brf_framer_sva.sv ***
// Purpose: Port-level checks for the block framer
// Assumes: One clock, srst synchronous active high
// Notes: Bound to every brf_framer instance
`default_nettype none
module brf_framer_sva (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Transmit side
  input wire logic tx_valid,
  input wire logic [31:0] tx_data,
  input wire logic tx_ready,
  input wire logic link_tx_valid,
  input wire logic [31:0] link_tx_data,
  input wire logic link_tx_ready,
  // Decoded fields
  input wire logic [1:0] speed_code,
  input wire logic speed_bad,
  input wire logic [1:0] retry_code,
  input wire logic retry_is_new,
  input wire logic [15:0] dest_node_id,
  input wire logic [9:0] dest_bus_num,
  input wire logic [5:0] dest_node_num,
  input wire logic [3:0] response_code,
  input wire logic response_reserved,
  // Receive side
  input wire logic rx_in_valid,
  input wire logic rx_in_ready,
  input wire logic grf_rd_valid,
  input wire logic [31:0] grf_rd_data,
  input wire logic grf_rd_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  property p_rdy; tx_ready == (!link_tx_valid || link_tx_ready); endproperty
  a_rdy: assert property (p_rdy) else $error("tx_ready wrong");
  property p_take; tx_valid && tx_ready |=> link_tx_valid && link_tx_data == $past(tx_data);
  endproperty
  a_take: assert property (p_take) else $error("quadlet not forwarded");
  property p_hold; link_tx_valid && !link_tx_ready |=> link_tx_valid && $stable(link_tx_data);
  endproperty
  a_hold: assert property (p_hold) else $error("link quadlet dropped");
  property p_spd; speed_bad == (speed_code == 2'h3); endproperty
  a_spd: assert property (p_spd) else $error("speed flag wrong");
  property p_rt; retry_is_new == (retry_code == 2'h0); endproperty
  a_rt: assert property (p_rt) else $error("retry decode wrong");
  property p_dest; dest_node_id == {dest_bus_num, dest_node_num}; endproperty
  a_dest: assert property (p_dest) else $error("destination split wrong");
  property p_rc; response_reserved == (response_code inside {[4'h1:4'h3], [4'h8:4'hF]});
  endproperty
  a_rc: assert property (p_rc) else $error("response flag wrong");
  property p_tok; !grf_rd_valid && rx_in_valid && !rx_in_ready |=> grf_rd_valid; endproperty
  a_tok: assert property (p_tok) else $error("token not stored");
  property p_grf; grf_rd_valid && !grf_rd_ready |=> grf_rd_valid && $stable(grf_rd_data);
  endproperty
  a_grf: assert property (p_grf) else $error("receive head changed");
endmodule // brf_framer_sva
bind brf_framer brf_framer_sva u_sva (.clk_sys, .srst, .tx_valid, .tx_data, .tx_ready,
  .link_tx_valid, .link_tx_data, .link_tx_ready, .speed_code, .speed_bad, .retry_code,
  .retry_is_new, .dest_node_id, .dest_bus_num, .dest_node_num, .response_code,
  .response_reserved, .rx_in_valid, .rx_in_ready, .grf_rd_valid, .grf_rd_data, .grf_rd_ready);
`default_nettype wire

// *** bench/brf_link_model.sv ***
// Purpose: Link sink taking transmit quadlets
// Assumes: Same clock as the framer
// Notes: Stall makes ready toggle so holds get exercised
`default_nettype none
module brf_link_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Transmit quadlets
  input wire logic link_tx_valid,
  input wire logic [31:0] link_tx_data,
  input wire logic link_tx_last,
  output var logic link_tx_ready,
  // Control
  input wire logic stall
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [32:0] cap[$];
  always @(posedge clk_sys) begin
    if (!srst && link_tx_valid && link_tx_ready) begin
      cap.push_back({link_tx_last, link_tx_data});
    end
    link_tx_ready <= srst ? 1'b1 : (stall ? !link_tx_ready : 1'b1);
  end
endmodule // brf_link_model
`default_nettype wire

// *** bench/block_response_and_receive_format_tb.sv ***
// Purpose: Self-checking bench for the block framer
// Assumes: Small receive FIFO so refusal on full is reached
// Notes: Inputs change 1 ns after the rising edge
`default_nettype none
module block_response_and_receive_format_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, srst = 1, tx_valid = 0, link_tx_ready, stall = 0, tx_ready;
  logic rx_in_valid = 0, rx_in_last = 0, grf_rd_ready = 0, rx_in_ready, rx_len_mismatch;
  logic [31:0] tx_data = 0, rx_in_data = 0, link_tx_data, grf_rd_data;
  logic [4:0] rx_in_status = 0;
  logic link_tx_valid, link_tx_last, speed_bad, retry_is_new, response_reserved;
  logic grf_rd_valid, grf_rd_last;
  logic [1:0] speed_code, retry_code;
  logic [5:0] transaction_label, dest_node_num;
  logic [3:0] transaction_code, response_code;
  logic [9:0] dest_bus_num;
  logic [15:0] dest_node_id, payload_byte_count, extended_transaction_code;
  int n_fail = 0, n_tests = 0;
  logic [3:0] rcs[6] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h7, 4'h3};
  logic [15:0] lens[6] = '{16'h0000, 16'h0005, 16'h0008, 16'h0003, 16'h0004, 16'h0001};
  brf_framer #(.GRF_DEPTH(4), .GRF_AW(2)) DUT (.clk_sys, .srst, .tx_valid, .tx_data,
    .tx_ready, .link_tx_valid, .link_tx_data, .link_tx_last, .link_tx_ready, .speed_code,
    .speed_bad, .transaction_label, .retry_code, .retry_is_new, .transaction_code,
    .dest_node_id, .dest_bus_num, .dest_node_num, .response_code, .response_reserved,
    .payload_byte_count, .extended_transaction_code, .rx_in_valid, .rx_in_data, .rx_in_last,
    .rx_in_status, .rx_in_ready, .rx_len_mismatch, .grf_rd_valid, .grf_rd_data, .grf_rd_last,
    .grf_rd_ready);
  brf_link_model M (.clk_sys, .srst, .link_tx_valid, .link_tx_data, .link_tx_last,
    .link_tx_ready, .stall);
  always #5 clk_sys = ~clk_sys;
  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Block response sent back to back, ready toggling on odd runs
  task automatic tx_pkt(input int i);
    logic [31:0] q[$];
    q.push_back({14'h0, i[1:0], i[2:0], 3'h5, i[1:0], 4'h7, 4'h0});
    q.push_back({10'h155, i[5:0], rcs[i], 12'h000});
    q.push_back(32'h5A5A_0000 + i);
    q.push_back({lens[i], 12'h000, i[3:0]});
    for (int k = 0; k < (lens[i] + 3) / 4; k++) q.push_back(32'hD000_0000 + k);
    stall = i[0];
    M.cap.delete();
    tx_valid = 1;
    foreach (q[k]) begin
      tx_data = q[k];
      while (tx_ready !== 1'b1) @(posedge clk_sys) #1;
      @(posedge clk_sys) #1;
    end
    tx_valid = 0;
    while (link_tx_valid !== 1'b0) @(posedge clk_sys) #1;
    chk("count", 33'(q.size()), 33'(M.cap.size()));
    foreach (q[k]) chk("quadlet", {k == q.size() - 1, q[k]}, M.cap[k]);
    chk("speed", 33'(i[1:0]), 33'(speed_code));
    chk("retry", 33'(i[1:0]), 33'(retry_code));
    chk("label", 33'({i[2:0], 3'h5}), 33'(transaction_label));
    chk("dest", 33'({10'h155, i[5:0]}), 33'(dest_node_id));
    chk("response_code", 33'(rcs[i]), 33'(response_code));
    chk("len", 33'(lens[i]), 33'(payload_byte_count));
    chk("ext", 33'(i[3:0]), 33'(extended_transaction_code));
    chk("transaction_code", 33'h7, 33'(transaction_code));
    chk("speed_bad", 33'(i[1:0] == 2'h3), 33'(speed_bad));
    chk("retry_new", 33'(i[1:0] == 2'h0), 33'(retry_is_new));
    chk("bus", 33'h155, 33'(dest_bus_num));
    chk("node", 33'(i[5:0]), 33'(dest_node_num));
    chk("rc_resv", 33'(rcs[i] inside {[4'h1:4'h3], [4'h8:4'hF]}), 33'(response_reserved));
  endtask
  function automatic logic [31:0] rq(input logic [3:0] tc, input int k);
    return k == 0 ? {16'h0005, 8'h00, tc, 4'h0} : k == 3 ? 32'h0005_0000 : 32'hA500_0000 + k;
  endfunction
  // Received packet pushed while host reads late, so the FIFO fills on packets of three quadlets or more
  // Link end flag raised at quadlet lk, which may disagree with the length
  task automatic rx_pkt(input logic [3:0] tc, input int n, input logic [4:0] st,
    input int lk);
    logic kn;
    kn = tc inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7, 4'hA};
    fork
      begin
        rx_in_status = st;
        rx_in_valid = 1;
        for (int k = 0; k < n; k++) begin
          rx_in_data = rq(tc, k);
          rx_in_last = (k == lk);
          while (rx_in_ready !== 1'b1) @(posedge clk_sys) #1;
          @(posedge clk_sys) #1;
          chk("len_mismatch", 33'((k == lk) != (k == n - 1)), 33'(rx_len_mismatch));
        end
        rx_in_valid = 0;
        rx_in_last = 0;
      end
      begin
        repeat (12) @(posedge clk_sys) #1;
        for (int k = -1; k < n; k++) begin
          while (grf_rd_valid !== 1'b1) @(posedge clk_sys) #1;
          if (k < 0) chk("token", {12'h000, st, 6'h00, kn, tc == 4'hA, tc, 4'h0},
            {grf_rd_last, grf_rd_data});
          else chk("grf", {k == n - 1, rq(tc, k)}, {grf_rd_last, grf_rd_data});
          grf_rd_ready = 1;
          @(posedge clk_sys) #1;
        end
        grf_rd_ready = 0;
      end
    join
  endtask
  // Reset mid packet: receive state and stored entries must be cleared
  task automatic reset_mid;
    rx_in_data = rq(4'h1, 0);
    rx_in_last = 0;
    rx_in_valid = 1;
    repeat (2) @(posedge clk_sys) #1;
    rx_in_valid = 0;
    srst = 1;
    repeat (2) @(posedge clk_sys) #1;
    srst = 0;
    chk("rst_grf", 33'h0, 33'(grf_rd_valid));
    chk("rst_rx_ready", 33'h0, 33'(rx_in_ready));
    chk("rst_speed", 33'h0, 33'(speed_code));
    chk("rst_tx_ready", 33'h1, 33'(tx_ready));
    chk("rst_link_valid", 33'h0, 33'(link_tx_valid));
  endtask
  initial begin
    repeat (3000) @(posedge clk_sys);
    n_fail++;
    print_verdict;
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    #1 srst = 0;
    chk("new", 33'h1, 33'(retry_is_new));
    chk("empty", 33'h0, 33'(grf_rd_valid));
    for (int i = 0; i < 6; i++) tx_pkt(i);
    rx_pkt(4'h1, 6, 5'h11, 5);
    rx_pkt(4'h2, 3, 5'h02, 2);
    rx_pkt(4'h6, 4, 5'h1F, 3);
    rx_pkt(4'hA, 3, 5'h04, 2);
    rx_pkt(4'h0, 4, 5'h01, 3);
    rx_pkt(4'h4, 3, 5'h06, 2);
    rx_pkt(4'h5, 6, 5'h07, 5);
    rx_pkt(4'h7, 6, 5'h09, 5);
    rx_pkt(4'h9, 2, 5'h0A, 1);
    rx_pkt(4'h2, 3, 5'h08, 1);
    reset_mid;
    tx_pkt(2);
    rx_pkt(4'h6, 4, 5'h03, 3);
    print_verdict;
  end
endmodule // block_response_and_receive_format_tb
`default_nettype wire
